// ---- pkg/spcr_defs.svh ----
// constants for the switch port control register bank
`ifndef SPCR_DEFS_SVH
`define SPCR_DEFS_SVH

// geometry
`define SPCR_NPORTS 10
`define SPCR_CPU_PORT 8
`define SPCR_DW 8
`define SPCR_HOST_AW 16
`define SPCR_I2C_AW 12

// address bases: i2c is base + n, host is base + 2n
`define SPCR_I2C_CTL1_BASE 12'h000
`define SPCR_I2C_CTL2_BASE 12'h00a
`define SPCR_HOST_CTL1_BASE 16'h0000
`define SPCR_HOST_CTL2_BASE 16'h0001

// reset values
`define SPCR_CTL1_RST 8'hc0
`define SPCR_CTL2_RST 8'h00

// port_control_one field positions
`define SPCR_C1_FLOW_DIS 0
`define SPCR_C1_HALF 1
`define SPCR_C1_SPD10 2
`define SPCR_C1_UP 3
`define SPCR_C1_MUST1 4
`define SPCR_C1_ASYM 5
`define SPCR_C1_SS_LO 6
`define SPCR_C1_SS_HI 7
`define SPCR_C1_RSVD_W 6

// port_control_two field positions
`define SPCR_C2_UNTAG 0
`define SPCR_C2_TAG 1
`define SPCR_C2_NOLEARN 2
`define SPCR_C2_SEC_LO 6
`define SPCR_C2_SEC_HI 7

// strap codes of the processor port interface mode pins
`define SPCR_MODE_PIN_SER 2'h1
`define SPCR_MODE_PIN_MII 2'h2

`endif

// ---- pkg/spcr_pkg.sv ----
// types shared by the switch port control register bank
package spcr_pkg;

  // spanning tree port state, in field encoding order
  typedef enum logic [1:0] {
    SPCR_SS_BLOCK,
    SPCR_SS_LISTEN,
    SPCR_SS_LEARN,
    SPCR_SS_FWD
  } spcr_ss_e;

  // processor port interface mode
  typedef enum logic [1:0] {
    SPCR_MODE_PARALLEL,
    SPCR_MODE_SERIAL,
    SPCR_MODE_SERIAL_MII
  } spcr_mode_e;

endpackage

// ---- verilog/spcr_port_ctl.sv ----
// one port: second control register and received frame verdict
`timescale 1ns/1ps
`default_nettype none
`include "spcr_defs.svh"

module spcr_port_ctl
  import spcr_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic wr_en_i,
  input wire logic [`SPCR_DW-1:0] wdata_i,
  input wire logic [1:0] state_i,
  input wire logic rx_sof_i,
  input wire logic rx_tagged_i,
  output logic [`SPCR_DW-1:0] ctl_o,
  output logic frm_valid_o,
  output logic frm_fwd_o,
  output logic frm_learn_o,
  output logic frm_to_cpu_o
);

  spcr_ss_e ss;
  logic viol;
  logic sec_on;
  logic next_fwd;
  logic next_learn;
  logic next_to_cpu;

  // register storage, written from either access path
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctl_o <= `SPCR_CTL2_RST; // [R14]
    end else if (wr_en_i) begin
      ctl_o <= wdata_i; // [R12]
    end
  end

  // frame classification from the settings in force at frame start
  always_comb begin
    ss = spcr_ss_e'(state_i);
    viol = (ctl_o[`SPCR_C2_UNTAG] && !rx_tagged_i) || // [R9]
           (ctl_o[`SPCR_C2_TAG] && rx_tagged_i); // [R10]
    sec_on = ctl_o[`SPCR_C2_SEC_HI] || ctl_o[`SPCR_C2_SEC_LO];
    next_fwd = (ss == SPCR_SS_FWD) && !viol; // [R1]
    next_learn = ((ss == SPCR_SS_FWD) || (ss == SPCR_SS_LEARN)) &&
                 !ctl_o[`SPCR_C2_NOLEARN] && !viol; // [R1] [R11]
    next_to_cpu = viol && sec_on && ctl_o[`SPCR_C2_SEC_HI]; // [R13]
  end

  // verdict is taken at each frame start and held until the next
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      frm_valid_o <= 1'b0;
      frm_fwd_o <= 1'b0;
      frm_learn_o <= 1'b0;
      frm_to_cpu_o <= 1'b0;
    end else begin
      frm_valid_o <= rx_sof_i; // [R14]
      if (rx_sof_i) begin
        frm_fwd_o <= next_fwd;
        frm_learn_o <= next_learn;
        frm_to_cpu_o <= next_to_cpu;
      end
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  chk_state_drop: assert property ( // [R1]
    rx_sof_i && !state_i[1] |=> !frm_fwd_o && !frm_learn_o)
    else $error("frame passed in blocking or listening state");
  chk_state_fwd: assert property ( // [R1]
    rx_sof_i && state_i == 2'h3 && !viol |=> frm_fwd_o)
    else $error("frame not forwarded in forwarding state");
  chk_untag_filter: assert property ( // [R9]
    rx_sof_i && ctl_o[`SPCR_C2_UNTAG] && !rx_tagged_i |=> !frm_fwd_o)
    else $error("untagged frame passed the filter");
  chk_tag_filter: assert property ( // [R10]
    rx_sof_i && ctl_o[`SPCR_C2_TAG] && rx_tagged_i |=> !frm_fwd_o)
    else $error("tagged frame passed the filter");
  chk_learn_off: assert property ( // [R11]
    rx_sof_i && ctl_o[`SPCR_C2_NOLEARN] |=> !frm_learn_o)
    else $error("address learned with learning disabled");
  chk_sec_cpu: assert property ( // [R13]
    rx_sof_i && viol && ctl_o[`SPCR_C2_SEC_HI]
    |=> frm_to_cpu_o && !frm_fwd_o)
    else $error("filtered frame not sent to processor");
  chk_verdict_time: assert property ( // [R14]
    wr_en_i && wdata_i[`SPCR_C2_UNTAG] ##1 rx_sof_i && !rx_tagged_i
    |=> frm_valid_o && !frm_fwd_o)
    else $error("frame start missed the register write");

  cov_filtered: cover property (rx_sof_i && viol);
  cov_to_cpu: cover property (rx_sof_i ##1 frm_to_cpu_o);

endmodule

`default_nettype wire

// ---- verilog/spcr_regs.sv ----
// switch port control registers: processor port and per-port filters
//
// How it works
// R1: state 00/01 drop; 10 drops but learns; 11 forwards and learns; reset 11.
// R2: in parallel or serial-only mode low six bits reserved; state only.
// R3: serial-plus-MII: bit 0 clear enables flow control, set disables.
// R4: serial-plus-MII: software keeps bit 1 at 0, so full duplex.
// R5: serial-plus-MII: bit 2 clear is 100 Mbps, set is 10 Mbps.
// R6: serial-plus-MII: bit 3 set forces MII up with bits 2..0; clear downs.
// R7: serial-plus-MII: software writes bit 4 as 1 on each configuration.
// R8: asymmetric bit with flow control on: no pause sent, pause still obeyed.
// R9: untagged filter set: untagged frames discarded or per security option.
// R10: tagged filter set: tagged frames discarded or per security option.
// R11: learning disable set stops source learning on that port.
// R12: second register reachable by i2c base+n and host 1+2n.
// R13: filtered frames under security: upper bit 0 discard, 1 to processor.
// R14: fields reset to defaults; writes apply by the next frame start.
`timescale 1ns/1ps
`default_nettype none
`include "spcr_defs.svh"

module spcr_regs
  import spcr_pkg::*;
#(
  parameter int NPORTS = `SPCR_NPORTS,
  parameter int CPU_PORT = `SPCR_CPU_PORT
)(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [1:0] cpu_mode_i,
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  input wire logic [`SPCR_HOST_AW-1:0] host_addr_i,
  input wire logic [`SPCR_DW-1:0] host_wdata_i,
  output logic [`SPCR_DW-1:0] host_rdata_o,
  output logic host_rvalid_o,
  input wire logic i2c_wr_i,
  input wire logic i2c_rd_i,
  input wire logic [`SPCR_I2C_AW-1:0] i2c_addr_i,
  input wire logic [`SPCR_DW-1:0] i2c_wdata_i,
  output logic [`SPCR_DW-1:0] i2c_rdata_o,
  output logic i2c_rvalid_o,
  input wire logic [2*NPORTS-1:0] ext_state_i,
  input wire logic [NPORTS-1:0] rx_sof_i,
  input wire logic [NPORTS-1:0] rx_tagged_i,
  output logic [NPORTS-1:0] frm_valid_o,
  output logic [NPORTS-1:0] frm_fwd_o,
  output logic [NPORTS-1:0] frm_learn_o,
  output logic [NPORTS-1:0] frm_to_cpu_o,
  output logic cpu_link_up_o,
  output logic cpu_flow_en_o,
  output logic cpu_pause_tx_o,
  output logic cpu_pause_rx_o,
  output logic cpu_speed_10_o,
  output logic cpu_half_duplex_o
);

  localparam int IW = $clog2(NPORTS);
  localparam logic [`SPCR_HOST_AW-1:0] HOST_CTL1_CPU =
    `SPCR_HOST_AW'(`SPCR_HOST_CTL1_BASE + 2 * CPU_PORT);
  localparam logic [`SPCR_I2C_AW-1:0] I2C_CTL1_CPU =
    `SPCR_I2C_AW'(`SPCR_I2C_CTL1_BASE + CPU_PORT);

  logic [1:0] mode_meta;
  logic [1:0] mode_sync;
  spcr_mode_e mode_q;
  logic mii;
  logic [`SPCR_DW-1:0] ctl1;
  logic [`SPCR_DW-1:0] ctl1_view;
  logic [`SPCR_DW-1:0] ctl2 [NPORTS];
  logic [`SPCR_HOST_AW-1:0] host_off;
  logic [`SPCR_I2C_AW-1:0] i2c_off;
  logic host_c1_hit;
  logic i2c_c1_hit;
  logic host_c2_hit;
  logic i2c_c2_hit;
  logic [IW-1:0] host_idx;
  logic [IW-1:0] i2c_idx;
  logic [`SPCR_DW-1:0] next_host_rdata;
  logic [`SPCR_DW-1:0] next_i2c_rdata;
  logic flow_on;

  // mode strap pins cross in through two flops
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_meta <= 2'h0;
      mode_sync <= 2'h0;
    end else begin
      mode_meta <= cpu_mode_i;
      mode_sync <= mode_meta;
    end
  end

  // decode the synchronised strap into the interface mode
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_q <= SPCR_MODE_PARALLEL;
    end else begin
      case (mode_sync)
        `SPCR_MODE_PIN_SER: mode_q <= SPCR_MODE_SERIAL;
        `SPCR_MODE_PIN_MII: mode_q <= SPCR_MODE_SERIAL_MII;
        default: mode_q <= SPCR_MODE_PARALLEL;
      endcase
    end
  end

  assign mii = (mode_q == SPCR_MODE_SERIAL_MII);

  // address decode for both access paths
  always_comb begin
    host_off = host_addr_i - `SPCR_HOST_CTL2_BASE;
    i2c_off = i2c_addr_i - `SPCR_I2C_CTL2_BASE;
    host_c1_hit = (host_addr_i == HOST_CTL1_CPU);
    i2c_c1_hit = (i2c_addr_i == I2C_CTL1_CPU);
    host_c2_hit = !host_off[0] && // [R12]
      (host_off[`SPCR_HOST_AW-1:1] < (`SPCR_HOST_AW-1)'(NPORTS));
    i2c_c2_hit = (i2c_off < `SPCR_I2C_AW'(NPORTS)); // [R12]
    host_idx = host_off[IW:1];
    i2c_idx = i2c_off[IW-1:0];
  end

  // processor port first control register; host wins a same-cycle clash
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctl1 <= `SPCR_CTL1_RST; // [R1] [R14]
    end else if (host_wr_i && host_c1_hit) begin
      ctl1 <= host_wdata_i;
    end else if (i2c_wr_i && i2c_c1_hit) begin
      ctl1 <= i2c_wdata_i;
    end
  end

  // reserved low bits read zero outside serial-plus-MII mode
  always_comb begin
    ctl1_view = ctl1;
    if (!mii) begin
      ctl1_view[`SPCR_C1_RSVD_W-1:0] = '0; // [R2]
    end
  end

  // one register and frame verdict per port
  for (genvar p = 0; p < NPORTS; p++) begin : g_port
    logic wr_host;
    logic wr_i2c;
    logic [1:0] st;
    assign wr_host = host_wr_i && host_c2_hit && (host_idx == IW'(p));
    assign wr_i2c = i2c_wr_i && i2c_c2_hit && (i2c_idx == IW'(p));
    // processor port state lives in its own first register
    assign st = (p == CPU_PORT) ?
      ctl1[`SPCR_C1_SS_HI:`SPCR_C1_SS_LO] : ext_state_i[2*p +: 2]; // [R1]
    spcr_port_ctl u_port (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .wr_en_i(wr_host || wr_i2c),
      .wdata_i(wr_host ? host_wdata_i : i2c_wdata_i),
      .state_i(st),
      .rx_sof_i(rx_sof_i[p]),
      .rx_tagged_i(rx_tagged_i[p]),
      .ctl_o(ctl2[p]),
      .frm_valid_o(frm_valid_o[p]),
      .frm_fwd_o(frm_fwd_o[p]),
      .frm_learn_o(frm_learn_o[p]),
      .frm_to_cpu_o(frm_to_cpu_o[p])
    );
  end

  // read data multiplexers; unmapped addresses read zero
  always_comb begin
    next_host_rdata = '0;
    next_i2c_rdata = '0;
    if (host_c1_hit) begin
      next_host_rdata = ctl1_view;
    end else if (host_c2_hit) begin
      next_host_rdata = ctl2[host_idx]; // [R12]
    end
    if (i2c_c1_hit) begin
      next_i2c_rdata = ctl1_view;
    end else if (i2c_c2_hit) begin
      next_i2c_rdata = ctl2[i2c_idx]; // [R12]
    end
  end

  // read answers one cycle after the strobe
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      host_rdata_o <= '0;
      host_rvalid_o <= 1'b0;
      i2c_rdata_o <= '0;
      i2c_rvalid_o <= 1'b0;
    end else begin
      host_rvalid_o <= host_rd_i;
      i2c_rvalid_o <= i2c_rd_i;
      if (host_rd_i) begin
        host_rdata_o <= next_host_rdata;
      end
      if (i2c_rd_i) begin
        i2c_rdata_o <= next_i2c_rdata;
      end
    end
  end

  assign flow_on = mii && !ctl1[`SPCR_C1_FLOW_DIS]; // [R3]

  // processor MII port settings, inert outside serial-plus-MII mode
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cpu_link_up_o <= 1'b0;
      cpu_flow_en_o <= 1'b0;
      cpu_pause_tx_o <= 1'b0;
      cpu_pause_rx_o <= 1'b0;
      cpu_speed_10_o <= 1'b0;
      cpu_half_duplex_o <= 1'b0;
    end else begin
      cpu_link_up_o <= mii && ctl1[`SPCR_C1_UP]; // [R6] [R2]
      cpu_flow_en_o <= flow_on; // [R3]
      cpu_pause_tx_o <= flow_on && !ctl1[`SPCR_C1_ASYM]; // [R8]
      cpu_pause_rx_o <= flow_on; // [R8]
      cpu_speed_10_o <= mii && ctl1[`SPCR_C1_SPD10]; // [R5]
      // software keeps this at full duplex
      cpu_half_duplex_o <= mii && ctl1[`SPCR_C1_HALF]; // [R4]
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  chk_link_up: assert property ( // [R6]
    mii && ctl1[`SPCR_C1_UP] ##1 mii |-> cpu_link_up_o)
    else $error("MII port not up with bit 3 set");
  chk_link_down: assert property ( // [R2]
    !mii |=> !cpu_link_up_o && !cpu_flow_en_o && !cpu_speed_10_o)
    else $error("reserved bits took effect outside MII mode");
  chk_flow_ctl: assert property ( // [R3]
    mii && !ctl1[`SPCR_C1_FLOW_DIS] |=> cpu_flow_en_o)
    else $error("flow control not enabled with bit 0 clear");
  chk_speed_sel: assert property ( // [R5]
    mii |=> cpu_speed_10_o == $past(ctl1[`SPCR_C1_SPD10]))
    else $error("speed output does not follow bit 2");
  chk_asym_pause: assert property ( // [R8]
    flow_on && ctl1[`SPCR_C1_ASYM] |=> !cpu_pause_tx_o && cpu_pause_rx_o)
    else $error("asymmetric pause handling wrong");
  chk_rsvd_read: assert property ( // [R2]
    host_rd_i && host_c1_hit && !mii
    |=> host_rvalid_o && host_rdata_o[`SPCR_C1_RSVD_W-1:0] == '0)
    else $error("reserved bits read non-zero");
  chk_host_rw: assert property ( // [R12]
    host_wr_i && host_c2_hit ##1 host_rd_i && host_c2_hit &&
    host_idx == $past(host_idx) && !i2c_wr_i
    |=> host_rdata_o == $past(host_wdata_i, 2))
    else $error("host path readback mismatch");
  chk_i2c_rw: assert property ( // [R12]
    i2c_wr_i && i2c_c2_hit && !host_wr_i ##1 i2c_rd_i && i2c_c2_hit &&
    i2c_idx == $past(i2c_idx) && !host_wr_i
    |=> i2c_rdata_o == $past(i2c_wdata_i, 2))
    else $error("i2c path readback mismatch");

  cov_mii_up: cover property (mii ##1 cpu_link_up_o);
  cov_asym: cover property (cpu_pause_rx_o && !cpu_pause_tx_o);
  cov_both_paths: cover property (host_wr_i && i2c_rd_i);

endmodule

`default_nettype wire

// ---- verification/spcr_regs_tb.sv ----
// self-checking bench for the switch port control register bank
`timescale 1ns/1ps
`default_nettype none

module spcr_regs_tb;
  typedef struct packed {
    logic [3:0] port;
    logic [7:0] c2;
    logic [1:0] st;
    logic tg;
    logic [2:0] e;
  } spcr_row_s;

  localparam int NR = 12;

  logic clk, rst, h_wr, h_rd, i_wr, i_rd;
  logic [1:0] mode;
  logic [15:0] h_addr;
  logic [11:0] i_addr;
  logic [7:0] h_wd, i_wd;
  logic [19:0] ext_st;
  logic [9:0] sof, tagd;
  wire [7:0] h_rdata, i_rdata;
  wire h_rv, i_rv;
  wire [9:0] fv, ffwd, flrn, fcpu;
  wire [5:0] cpu;
  int err_total, samples_checked;

  // frame rows: port, second register, state, tagged, {fwd, learn, to cpu}
  spcr_row_s rows [NR] = '{
    '{4'h0, 8'h00, 2'h3, 1'b0, 3'b110},
    '{4'h1, 8'h00, 2'h2, 1'b1, 3'b010},
    '{4'h2, 8'h00, 2'h1, 1'b0, 3'b000},
    '{4'h3, 8'h00, 2'h0, 1'b1, 3'b000},
    '{4'h4, 8'h01, 2'h3, 1'b0, 3'b000},
    '{4'h4, 8'h01, 2'h3, 1'b1, 3'b110},
    '{4'h5, 8'h02, 2'h3, 1'b1, 3'b000},
    '{4'h5, 8'h02, 2'h3, 1'b0, 3'b110},
    '{4'h6, 8'h04, 2'h3, 1'b0, 3'b100},
    '{4'h7, 8'h81, 2'h3, 1'b0, 3'b001},
    '{4'h9, 8'h42, 2'h3, 1'b1, 3'b000},
    '{4'h9, 8'hc2, 2'h2, 1'b1, 3'b001}
  };

  // processor port setups: value, {link, flow, pause tx, pause rx, 10m, half}
  logic [13:0] mii [6] = '{
    {8'hd0, 6'b011100},
    {8'hd8, 6'b111100},
    {8'hdc, 6'b111110},
    {8'hf8, 6'b110100},
    {8'hd9, 6'b100000},
    {8'hf9, 6'b100000}
  };

  spcr_regs spcr_regs_i (
    .core_clk_i(clk), .rst_i(rst), .cpu_mode_i(mode),
    .host_wr_i(h_wr), .host_rd_i(h_rd), .host_addr_i(h_addr),
    .host_wdata_i(h_wd), .host_rdata_o(h_rdata), .host_rvalid_o(h_rv),
    .i2c_wr_i(i_wr), .i2c_rd_i(i_rd), .i2c_addr_i(i_addr),
    .i2c_wdata_i(i_wd), .i2c_rdata_o(i_rdata), .i2c_rvalid_o(i_rv),
    .ext_state_i(ext_st), .rx_sof_i(sof), .rx_tagged_i(tagd),
    .frm_valid_o(fv), .frm_fwd_o(ffwd), .frm_learn_o(flrn),
    .frm_to_cpu_o(fcpu), .cpu_link_up_o(cpu[5]), .cpu_flow_en_o(cpu[4]),
    .cpu_pause_tx_o(cpu[3]), .cpu_pause_rx_o(cpu[2]),
    .cpu_speed_10_o(cpu[1]), .cpu_half_duplex_o(cpu[0])
  );

  // 125 MHz core clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] got);
    samples_checked++;
    if (got !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, got);
    end
  endtask

  // second register address of port p on either path
  function automatic logic [15:0] a2(input bit on_i2c, input int p);
    return on_i2c ? 16'(32'h00a + p) : 16'(32'h001 + 2 * p);
  endfunction

  // one write after an idle cycle, raised and released at falling edges
  task automatic wr(input bit on_i2c, input logic [15:0] a,
                    input logic [7:0] d);
    @(negedge clk);
    if (on_i2c) begin
      i_wr = 1'b1;
      i_addr = a[11:0];
      i_wd = d;
    end else begin
      h_wr = 1'b1;
      h_addr = a;
      h_wd = d;
    end
    @(negedge clk);
    if (on_i2c) begin
      i_wr = 1'b0;
    end else begin
      h_wr = 1'b0;
    end
  endtask

  // one read after an idle cycle; answer stands the cycle after the strobe
  task automatic rd(input bit on_i2c, input logic [15:0] a,
                    input logic [7:0] e, input string nm);
    @(negedge clk);
    if (on_i2c) begin
      i_rd = 1'b1;
      i_addr = a[11:0];
    end else begin
      h_rd = 1'b1;
      h_addr = a;
    end
    @(negedge clk);
    if (on_i2c) begin
      i_rd = 1'b0;
    end else begin
      h_rd = 1'b0;
    end
    chk({nm, " rvalid"}, 8'h01, {7'h0, on_i2c ? i_rv : h_rv});
    chk(nm, e, on_i2c ? i_rdata : h_rdata);
  endtask

  // write, then read the same register in the very next cycle
  task automatic wr_rd(input bit on_i2c, input logic [15:0] a,
                       input logic [7:0] d, input string nm);
    @(negedge clk);
    if (on_i2c) begin
      i_wr = 1'b1;
      i_addr = a[11:0];
      i_wd = d;
    end else begin
      h_wr = 1'b1;
      h_addr = a;
      h_wd = d;
    end
    @(negedge clk);
    if (on_i2c) begin
      i_wr = 1'b0;
      i_rd = 1'b1;
    end else begin
      h_wr = 1'b0;
      h_rd = 1'b1;
    end
    @(negedge clk);
    if (on_i2c) begin
      i_rd = 1'b0;
    end else begin
      h_rd = 1'b0;
    end
    chk({nm, " rvalid"}, 8'h01, {7'h0, on_i2c ? i_rv : h_rv});
    chk(nm, d, on_i2c ? i_rdata : h_rdata);
  endtask

  // one frame start; verdict is checked in the following cycle
  task automatic frame(input int p, input logic tg, input logic [2:0] e,
                       input string nm);
    sof[p] = 1'b1;
    tagd[p] = tg;
    @(negedge clk);
    sof[p] = 1'b0;
    chk(nm, {5'h01, e}, {4'h0, fv[p], ffwd[p], flrn[p], fcpu[p]});
  endtask

  task automatic do_reset();
    rst = 1'b1;
    repeat (12) @(negedge clk);
    rst = 1'b0;
  endtask

  // watchdog against a hung run
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    final_report();
  end

  // main sequence
  initial begin
    {h_wr, h_rd, i_wr, i_rd, h_addr, i_addr, h_wd, i_wd} = '0;
    {ext_st, sof, tagd, mode} = '0;
    err_total = 0;
    samples_checked = 0;
    do_reset();
    rd(1'b0, 16'h0010, 8'hc0, "ctl1 reset host");
    rd(1'b1, 16'h0008, 8'hc0, "ctl1 reset i2c");
    for (int p = 0; p < 10; p++) begin
      rd(p[0], a2(p[0], p), 8'h00, "ctl2 reset");
    end
    chk("cpu mii reset", 8'h00, {2'h0, cpu});
    for (int r = 0; r < NR; r++) begin
      int pt;
      pt = int'(rows[r].port);
      wr(r[0], a2(r[0], pt), rows[r].c2);
      rd(!r[0], a2(!r[0], pt), rows[r].c2, "ctl2 back");
      ext_st[2 * pt +: 2] = rows[r].st;
      frame(pt, rows[r].tg, rows[r].e, "verdict");
    end
    // a write lands before a frame that starts in the next cycle
    ext_st[5:4] = 2'h3;
    wr(1'b0, a2(1'b0, 2), 8'h01);
    frame(2, 1'b0, 3'b000, "verdict after write");
    // simultaneous writes to one register
    h_wr = 1'b1;
    h_addr = a2(1'b0, 3);
    h_wd = 8'h02;
    i_wr = 1'b1;
    i_addr = 12'h00d;
    i_wd = 8'h04;
    @(negedge clk);
    h_wr = 1'b0;
    i_wr = 1'b0;
    rd(1'b1, a2(1'b1, 3), 8'h02, "write clash");
    // read straight after a write on each path
    wr_rd(1'b0, a2(1'b0, 6), 8'h33, "host back to back");
    wr_rd(1'b1, a2(1'b1, 7), 8'h55, "i2c back to back");
    wr(1'b0, 16'h0fff, 8'h5a);
    rd(1'b0, 16'h0fff, 8'h00, "unmapped");
    // processor port outside serial plus mii mode, duplex bit kept clear
    wr(1'b0, 16'h0010, 8'hbd);
    rd(1'b0, 16'h0010, 8'h80, "ctl1 parallel");
    chk("cpu mii parallel", 8'h00, {2'h0, cpu});
    ext_st[17:16] = 2'h3;
    frame(8, 1'b0, 3'b010, "cpu port learn");
    mode = 2'h1;
    repeat (4) @(negedge clk);
    rd(1'b1, 16'h0008, 8'h80, "ctl1 serial");
    chk("cpu mii serial", 8'h00, {2'h0, cpu});
    // serial plus mii mode
    mode = 2'h2;
    repeat (4) @(negedge clk);
    rd(1'b0, 16'h0010, 8'hbd, "ctl1 mii");
    for (int k = 0; k < 6; k++) begin
      wr(k[0], k[0] ? 16'h0008 : 16'h0010, mii[k][13:6]);
      @(negedge clk);
      chk("cpu mii", {2'h0, mii[k][5:0]}, {2'h0, cpu});
    end
    rd(1'b1, 16'h0008, 8'hf9, "ctl1 mii back");
    // second reset in mid-run
    do_reset();
    rd(1'b0, 16'h0010, 8'hc0, "ctl1 rereset");
    rd(1'b1, a2(1'b1, 9), 8'h00, "ctl2 rereset");
    repeat (3) @(negedge clk);
    chk("cpu mii rereset", 8'h1c, {2'h0, cpu});
    final_report();
  end
endmodule
`default_nettype wire
